// [design/rf_fe_pkg.sv]
package rf_fe_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [4:0] FRAME_LAST = 5'h17;   // index of the 24th clock edge
  localparam logic [4:0] FRAME_DONE = 5'h18;   // edges beyond this are ignored
  localparam logic [4:0] HDR_BITS = 5'h08;     // read/write flag plus address
  localparam int RW_POS = 22;                  // flag position one edge before the last
  localparam int ADDR_HI = 21;
  localparam int ADDR_LO = 15;
  localparam int DATA_HI_PRE = 14;             // data bits held before the last edge

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] RF_FRONTEND_CONTROL_ADDR = 7'h23;
  localparam logic [6:0] BALUN_TUNING_ADDR = 7'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SRC_SEL_BIT = 11;
  localparam int REG_SEL_HI = 10;
  localparam int REG_SEL_LO = 9;
  localparam int ATTEN_HI = 8;
  localparam int ATTEN_LO = 5;
  localparam int BAL_PRI_HI = 3;
  localparam int BAL_PRI_LO = 1;
  localparam int BAL_SEC_HI = 7;
  localparam int BAL_SEC_LO = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic SRC_SEL_RST = 1'b0;         // serial register control
  localparam logic [1:0] REG_SEL_RST = 2'h0;
  localparam logic [3:0] ATTEN_RST = 4'h0;
  localparam logic [2:0] BAL_CAP_RST = 3'h0;
  localparam logic [3:0] RF_INPUT_ONEHOT_RST = 4'h1;
  localparam logic [3:0] ONEHOT_BASE = 4'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int SWITCH_TIME_NS = 100;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS * CLK_MHZ) / 1000;  // longest: round down

endpackage

// [design/pin_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser, one chain per bit
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // per-bit chains
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q[gi] <= 1'b0;
          sync_o[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_i[gi];
          sync_o[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule

// [design/rf_front_end_select_control.sv]
`timescale 1ns/1ps
// Summary of operation
// R01: source bit at 0x23[11] picks register field (0) or select pins (1).
// R02: after reset the input is chosen by the register field.
// R03: register field 0x23[10:9] value n selects input n; pins ignored.
// R04: pins {msb,lsb} value n selects input n; register field ignored.
// R05: input follows a pin change within 100 ns; serial adds frame latency.
// R06: primary balun capacitor code sits at 0x30[3:1].
// R07: secondary balun capacitor code sits at 0x30[7:5], independent of primary.
// R08: attenuator step code sits at 0x23[8:5], 1 dB per code.
// R09: source change applies at once; fields hold until rewritten.
module rf_front_end_select_control
  import rf_fe_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SDIO_I,
  output logic SPI_SDIO_O,
  output logic SPI_SDIO_OE_N_O,
  input wire logic RF_INPUT_PIN_LSB_I,
  input wire logic RF_INPUT_PIN_MSB_I,
  output logic [3:0] RF_INPUT_EN_O,
  output logic RF_INPUT_SOURCE_SEL_O,
  output logic [3:0] RF_ATTEN_STEP_O,
  output logic [2:0] BALUN_PRIMARY_CAP_O,
  output logic [2:0] BALUN_SECONDARY_CAP_O
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_s;
  pin_sync #(.W(5)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i({RF_INPUT_PIN_MSB_I, RF_INPUT_PIN_LSB_I, SPI_SDIO_I, SPI_CS_N_I, SPI_SCLK_I}),
    .sync_o(sync_s)
  );

  wire sclk_s = sync_s[0];
  wire cs_n_s = sync_s[1];
  wire sdio_s = sync_s[2];
  wire [1:0] pin_sel_s = sync_s[4:3];

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [23:0] shift_q;
  logic [15:0] rdsh_q;
  logic sdo_q;
  logic oe_n_q;

  // edges seen at 40 MHz, so the serial clock must stay well below a quarter of it
  wire sclk_rise = sclk_s && !sclk_q && !cs_n_s;
  wire sclk_fall = !sclk_s && sclk_q && !cs_n_s;
  wire bit_take = sclk_rise && (cnt_q < FRAME_DONE);
  wire [23:0] shift_d = {shift_q[22:0], sdio_s};
  wire frame_end = bit_take && (cnt_q == FRAME_LAST);
  wire wr_rw = shift_q[RW_POS];
  wire [6:0] wr_addr = shift_q[ADDR_HI:ADDR_LO];
  wire [15:0] wr_data = {shift_q[DATA_HI_PRE:0], sdio_s};
  wire wr_commit = frame_end && !wr_rw;
  wire wr_ctrl = wr_commit && (wr_addr == RF_FRONTEND_CONTROL_ADDR);
  wire wr_balun = wr_commit && (wr_addr == BALUN_TUNING_ADDR);

  // read header complete: flag and address now in the low byte
  wire rd_hdr = shift_q[HDR_BITS-1];
  wire [6:0] rd_addr = shift_q[ADDR_W-1:0];
  wire rd_load = sclk_fall && (cnt_q == HDR_BITS) && rd_hdr;
  wire rd_shift = sclk_fall && (cnt_q > HDR_BITS) && !oe_n_q;

  // bit counter and input shifter, cleared whenever chip select is high
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sclk_q <= 1'b0;
      cnt_q <= 5'h0;
      shift_q <= 24'h00_0000;
    end else begin
      sclk_q <= sclk_s;
      if (cs_n_s) begin
        cnt_q <= 5'h0;
        shift_q <= 24'h00_0000;
      end else if (bit_take) begin
        cnt_q <= cnt_q + 5'h1;
        shift_q <= shift_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  logic src_q;
  logic [1:0] reg_sel_q;
  logic [3:0] atten_q;
  logic [2:0] bal_pri_q;
  logic [2:0] bal_sec_q;

  // fields change only on a complete write frame to their own offset
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_q <= SRC_SEL_RST; // R02
      reg_sel_q <= REG_SEL_RST;
      atten_q <= ATTEN_RST;
      bal_pri_q <= BAL_CAP_RST;
      bal_sec_q <= BAL_CAP_RST;
    end else begin
      if (wr_ctrl) begin
        src_q <= wr_data[SRC_SEL_BIT]; // R01
        reg_sel_q <= wr_data[REG_SEL_HI:REG_SEL_LO]; // R03
        atten_q <= wr_data[ATTEN_HI:ATTEN_LO]; // R08
      end
      if (wr_balun) begin
        bal_pri_q <= wr_data[BAL_PRI_HI:BAL_PRI_LO]; // R06
        bal_sec_q <= wr_data[BAL_SEC_HI:BAL_SEC_LO]; // R07
      end
    end
  end

  // readback; bits outside this block's fields read as zero
  wire [15:0] ctrl_rd = {4'h0, src_q, reg_sel_q, atten_q, 5'h00};
  wire [15:0] balun_rd = {8'h00, bal_sec_q, 1'b0, bal_pri_q, 1'b0};
  wire [15:0] rd_data = (rd_addr == RF_FRONTEND_CONTROL_ADDR) ? ctrl_rd :
                        (rd_addr == BALUN_TUNING_ADDR) ? balun_rd : 16'h0000;

  // read data leaves msb first, one bit per falling serial edge
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdsh_q <= 16'h0000;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (cs_n_s) begin
      oe_n_q <= 1'b1;
      sdo_q <= 1'b0;
    end else if (rd_load) begin
      rdsh_q <= {rd_data[14:0], 1'b0};
      sdo_q <= rd_data[15];
      oe_n_q <= 1'b0;
    end else if (rd_shift) begin
      rdsh_q <= {rdsh_q[14:0], 1'b0};
      sdo_q <= rdsh_q[15];
    end
  end

  // ----------------------------------------------------------------
  // input switch
  // ----------------------------------------------------------------
  // pins pass the synchroniser, so a pin change shows three cycles later
  wire [1:0] active_sel = src_q ? pin_sel_s : reg_sel_q; // R01 R03 R04 R09
  wire [3:0] act_d = ONEHOT_BASE << active_sel;
  logic [3:0] act_q;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      act_q <= RF_INPUT_ONEHOT_RST;
    end else begin
      act_q <= act_d; // R05
    end
  end

  assign RF_INPUT_EN_O = act_q;
  assign RF_INPUT_SOURCE_SEL_O = src_q;
  assign RF_ATTEN_STEP_O = atten_q;
  assign BALUN_PRIMARY_CAP_O = bal_pri_q;
  assign BALUN_SECONDARY_CAP_O = bal_sec_q;
  assign SPI_SDIO_O = sdo_q;
  assign SPI_SDIO_OE_N_O = oe_n_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  wire [1:0] pins_raw = {RF_INPUT_PIN_MSB_I, RF_INPUT_PIN_LSB_I};

  sequence s_pin_move;
    src_q && $changed(pins_raw);
  endsequence

  sequence s_pin_settle;
    (src_q && $stable(pins_raw))[*3];
  endsequence

  property p_reg_mode;
    !src_q |=> RF_INPUT_EN_O == (ONEHOT_BASE << $past(reg_sel_q));
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register mode input wrong"); // R03

  property p_reset_src;
    $rose(RST_N_I) |-> !src_q && RF_INPUT_EN_O == RF_INPUT_ONEHOT_RST;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("not under register control"); // R02

  property p_pin_mode;
    src_q ##1 src_q |=> RF_INPUT_EN_O == (ONEHOT_BASE << $past(pin_sel_s));
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode input wrong"); // R04

  property p_pin_time;
    s_pin_move ##1 s_pin_settle |-> RF_INPUT_EN_O == (ONEHOT_BASE << pins_raw);
  endproperty
  a_pin_time: assert property (p_pin_time) else $error("pin switch too slow"); // R05

  property p_src_write;
    wr_ctrl |=> src_q == $past(wr_data[SRC_SEL_BIT]) ##1
      RF_INPUT_EN_O == (ONEHOT_BASE << (src_q ? $past(pin_sel_s) : reg_sel_q));
  endproperty
  a_src_write: assert property (p_src_write) else $error("source change not applied"); // R01

  property p_balun;
    wr_balun |=> BALUN_PRIMARY_CAP_O == $past(wr_data[BAL_PRI_HI:BAL_PRI_LO]) &&
      BALUN_SECONDARY_CAP_O == $past(wr_data[BAL_SEC_HI:BAL_SEC_LO]);
  endproperty
  a_balun: assert property (p_balun) else $error("balun code not taken"); // R06

  property p_balun_split;
    wr_ctrl |=> $stable(BALUN_SECONDARY_CAP_O) && $stable(BALUN_PRIMARY_CAP_O);
  endproperty
  a_balun_split: assert property (p_balun_split) else $error("balun code disturbed"); // R07

  property p_atten;
    wr_ctrl |=> RF_ATTEN_STEP_O == $past(wr_data[ATTEN_HI:ATTEN_LO]);
  endproperty
  a_atten: assert property (p_atten) else $error("attenuator code not taken"); // R08

  property p_hold;
    !wr_commit |=> $stable(src_q) && $stable(reg_sel_q) && $stable(RF_ATTEN_STEP_O);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed without write"); // R09

endmodule

// [dv/spi_host.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial port host: mode 0, clock idle low, still between frames
// ------------------------------------------------------------
module spi_host (
  input wire logic clk_i,
  input wire logic sdio_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
  end

  // phases of 4 cycles keep margin over the 3-cycle synchroniser minimum
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [23:0] f;
    f = {rd, addr, wd};
    rdat = 16'h0000;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      // released line during read data toggles, so a stale copy cannot pass
      sdio_o = (rd && i < 16) ? ~sdio_o : f[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      if (i < 16) rdat[i] = sdio_i;
    end
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import rf_fe_pkg::*;
  logic clk, rst_n, pin_lsb, pin_msb;
  wire sclk, cs_n, host_sdio, sdio_w, sdo, oe_n, src;
  wire [3:0] en, atten;
  wire [2:0] pri, sec;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h4b91_3cdb;
  logic [15:0] d, v, c;

  // shared data line: device wins while its enable is low
  assign sdio_w = oe_n ? host_sdio : sdo;

  rf_front_end_select_control rf_front_end_select_control_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
    .SPI_SDIO_I(sdio_w), .SPI_SDIO_O(sdo), .SPI_SDIO_OE_N_O(oe_n),
    .RF_INPUT_PIN_LSB_I(pin_lsb), .RF_INPUT_PIN_MSB_I(pin_msb),
    .RF_INPUT_EN_O(en), .RF_INPUT_SOURCE_SEL_O(src), .RF_ATTEN_STEP_O(atten),
    .BALUN_PRIMARY_CAP_O(pri), .BALUN_SECONDARY_CAP_O(sec));

  spi_host spi_host_inst (.clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdio_o(host_sdio));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected one-hot enable for an input index, bit n for input n
  function automatic logic [15:0] exp_en(input logic [1:0] idx);
    return 16'h0001 << idx;
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: roughly three times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    pin_lsb = 1'b0;
    pin_msb = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("en_rst", en, 16'h0001);
    chk("src_rst", src, 16'h0000);
    // register control: every select code, pins scrambled to show they are ignored
    for (int k = 0; k < 8; k++) begin
      d = rnd() & 16'hF7FF;
      d[10:9] = k[1:0];
      {pin_msb, pin_lsb} = rnd();
      spi_host_inst.xfer(1'b0, RF_FRONTEND_CONTROL_ADDR, d, v);
      c = d;
      chk("en_reg", en, exp_en(c[10:9]));
      chk("atten", atten, c[8:5]);
      // pins move after the write; the field keeps its hold on the switch
      {pin_msb, pin_lsb} = ~{pin_msb, pin_lsb};
      repeat (4) @(negedge clk);
      chk("en_reg_pins", en, exp_en(c[10:9]));
      d = rnd();
      spi_host_inst.xfer(1'b0, BALUN_TUNING_ADDR, d, v);
      chk("pri", pri, d[3:1]);
      chk("sec", sec, d[7:5]);
      spi_host_inst.xfer(1'b1, BALUN_TUNING_ADDR, 16'h0000, v);
      chk("rd30", v, d & 16'h00EE);
    end
    spi_host_inst.xfer(1'b1, RF_FRONTEND_CONTROL_ADDR, 16'h0000, v);
    chk("atten_hold", atten, c[8:5]);
    chk("rd23_hold", v, c & 16'h0FE0);
    chk("oe_idle", oe_n, 16'h0001);
    // pin control: field fixed at 3, pins walk all codes
    spi_host_inst.xfer(1'b0, RF_FRONTEND_CONTROL_ADDR, 16'h0E00, v);
    chk("src_pin", src, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      {pin_msb, pin_lsb} = k[1:0] ^ 2'h2;
      repeat (4) @(negedge clk);
      chk("en_pin", en, exp_en({pin_msb, pin_lsb}));
    end
    // back to register control: follows the field at once
    spi_host_inst.xfer(1'b0, RF_FRONTEND_CONTROL_ADDR, 16'h0400, v);
    chk("en_back", en, exp_en(2'h2));
    // unmapped place: write ignored, read gives zero
    spi_host_inst.xfer(1'b0, 7'h24, 16'hFFFF, v);
    spi_host_inst.xfer(1'b1, 7'h24, 16'h0000, v);
    chk("rd_unmapped", v, 16'h0000);
    spi_host_inst.xfer(1'b1, RF_FRONTEND_CONTROL_ADDR, 16'h0000, v);
    chk("rd23", v, 16'h0400);
    test_done();
  end
endmodule
